// file: include/efc_pkg.sv
// Purpose: constants for the echo front end configuration registers
// Assumes: serial frame of 16 bits, read flag and address first
// Notes: offsets are register addresses on the serial link
package efc_pkg;
    localparam int CLK_HZ_DEF = 10_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam logic [5:0] OFF_LOG_TUNE = 6'h12;
    localparam logic [5:0] OFF_RX_GAIN = 6'h13;
    localparam logic [5:0] OFF_IO_CFG = 6'h14;
    localparam logic [5:0] OFF_SUPPLY = 6'h16;
    localparam logic [5:0] OFF_FAULT_STAT = 6'h1C;
    localparam logic [7:0] LOG_TUNE_RST = 8'h00;
    localparam logic [7:0] RX_GAIN_RST = 8'h00;
    localparam logic [7:0] IO_CFG_RST = 8'h00;
    localparam logic [7:0] SUPPLY_RST = 8'h20;
    localparam logic [7:0] LOG_TUNE_MASK = 8'hFF;
    localparam logic [7:0] RX_GAIN_MASK = 8'hC7;
    localparam logic [7:0] IO_CFG_MASK = 8'h1F;
    localparam logic [7:0] SUPPLY_MASK = 8'h7F;
    localparam int B_OVERRIDE = 7;
    localparam int SLOPE_HI = 6;
    localparam int SLOPE_LO = 4;
    localparam int ICPT_HI = 3;
    localparam int ICPT_LO = 0;
    localparam int B_FIRST_OFF = 7;
    localparam int B_FINAL_OFF = 6;
    localparam int B_SCALE = 2;
    localparam int GAIN_HI = 1;
    localparam int GAIN_LO = 0;
    localparam int DG_HI = 4;
    localparam int DG_LO = 2;
    localparam int MODE_HI = 1;
    localparam int MODE_LO = 0;
    localparam int B_AUTO_OFF = 6;
    localparam int B_HIZ = 5;
    localparam int B_CURRENT = 4;
    localparam int VOLT_HI = 3;
    localparam int VOLT_LO = 0;
    localparam int STAT_READY = 5;
    localparam int STAT_FAULT = 3;
    localparam int STAT_STATE_HI = 1;
    localparam int STAT_STATE_LO = 0;
    localparam int BIT_RW = 15;
    localparam int ADDR_HI = 14;
    localparam int ADDR_LO = 9;
    localparam int HDR_RW = 7;
    localparam int HDR_A_HI = 6;
    localparam int HDR_A_LO = 1;
    localparam logic [3:0] HDR_LAST = 4'h7;
    localparam logic [3:0] FRAME_LAST = 4'hF;
    localparam logic [1:0] IO_MODE_DUAL = 2'h2;
    localparam logic [1:0] IO_MODE_NOCHK = 2'h3;
    localparam logic [2:0] DG_OFF = 3'h7;
    localparam int DG_US_0 = 64;
    localparam int DG_US_1 = 48;
    localparam int DG_US_2 = 32;
    localparam int DG_US_3 = 24;
    localparam int DG_US_4 = 16;
    localparam int DG_US_5 = 8;
    localparam int DG_US_6 = 4;

    typedef enum logic [0:0] {DET_IDLE = 1'b0, DET_ARMED = 1'b1} efc_det_e;

    // quiet cycles allowed for a deglitch code; zero when disabled
    function automatic int dg_cycles(input logic [2:0] code, input int hz);
        int us;
        case (code)
            3'h0: us = DG_US_0;
            3'h1: us = DG_US_1;
            3'h2: us = DG_US_2;
            3'h3: us = DG_US_3;
            3'h4: us = DG_US_4;
            3'h5: us = DG_US_5;
            3'h6: us = DG_US_6;
            default: us = 0;
        endcase
        return (us * (hz / 1000)) / (US_PER_S / 1000);
    endfunction : dg_cycles
endpackage : efc_pkg

// file: include/efc_fault_if.sv
// Purpose: carries pulse fault checker configuration, pins and result
// Assumes: single clock, all signals synchronous to it
// Notes: fault_set is a one-cycle pulse
`timescale 1ns/1ns
interface efc_fault_if;
    logic [1:0] io_mode;
    logic [2:0] deglitch;
    logic burst_start;
    logic burst_active;
    logic pin_a;
    logic pin_b;
    logic fault_set;
    modport ctl (output io_mode, deglitch, burst_start, burst_active,
        pin_a, pin_b, input fault_set);
    modport det (input io_mode, deglitch, burst_start, burst_active,
        pin_a, pin_b, output fault_set);
endinterface : efc_fault_if

// file: core/efc_pulse_fault_det.sv
// Purpose: watches burst pins for a stuck driver during a burst
// Assumes: pins synchronous to ref_clk, burst_active high while bursting
// Notes: in dual mode one count covers both pins
`timescale 1ns/1ns
module efc_pulse_fault_det #(
    parameter int CLK_HZ = efc_pkg::CLK_HZ_DEF,
    parameter int CNT_W = 10
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // checker side of the carrier
    efc_fault_if.det bus
);
    localparam int MAX_CYC = efc_pkg::dg_cycles(3'h0, CLK_HZ);
    if (MAX_CYC < 1 || MAX_CYC >= (1 << CNT_W))
    begin : g_bad_cfg
        $error("quiet counter cannot hold the longest deglitch");
    end

    efc_pkg::efc_det_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic a_q, b_q;

    wire tog_a = bus.pin_a ^ a_q;
    wire tog_b = bus.pin_b ^ b_q;
    wire dual = bus.io_mode == efc_pkg::IO_MODE_DUAL;
    wire check_on = bus.io_mode != efc_pkg::IO_MODE_NOCHK
        && bus.deglitch != efc_pkg::DG_OFF;
    wire hold = dual && bus.pin_a && bus.pin_b;
    wire moved = dual ? (tog_a | tog_b) : tog_b;
    wire [CNT_W-1:0] limit =
        CNT_W'(efc_pkg::dg_cycles(bus.deglitch, CLK_HZ));
    // count reaching the limit means quiet for longer than the time
    wire expired = state_q == efc_pkg::DET_ARMED && check_on
        && !moved && !hold && cnt_q == limit;

    assign bus.fault_set = expired;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            efc_pkg::DET_IDLE:
                if (bus.burst_start && check_on)
                begin
                    state_d = efc_pkg::DET_ARMED;
                    cnt_d = '0;
                end
            efc_pkg::DET_ARMED:
                if (expired || (!bus.burst_active && !bus.burst_start))
                    state_d = efc_pkg::DET_IDLE;
                else if (moved || hold)
                    cnt_d = '0;
                else
                    cnt_d = cnt_q + 1'b1;
            default: state_d = efc_pkg::DET_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= efc_pkg::DET_IDLE;
            cnt_q <= '0;
            a_q <= 1'b0;
            b_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            a_q <= bus.pin_a;
            b_q <= bus.pin_b;
        end
    end

    chk_fault_at_limit: assert property (@(posedge ref_clk)
        disable iff (!nrst) bus.fault_set |-> cnt_q == limit
            && $past(state_q) == efc_pkg::DET_ARMED)
        else $error("fault raised before deglitch time ran out");
    chk_disabled_quiet: assert property (@(posedge ref_clk)
        disable iff (!nrst) (bus.deglitch == efc_pkg::DG_OFF
            || bus.io_mode == efc_pkg::IO_MODE_NOCHK) |-> !bus.fault_set)
        else $error("fault raised while check disabled");
    chk_toggle_clears: assert property (@(posedge ref_clk)
        disable iff (!nrst) state_q == efc_pkg::DET_ARMED && moved
            && !bus.fault_set && bus.burst_active |=> cnt_q == '0)
        else $error("pin toggle did not restart quiet count");
    cov_fault: cover property (@(posedge ref_clk) disable iff (!nrst)
        bus.fault_set);
endmodule : efc_pulse_fault_det

// file: core/efc_config_regs.sv
// Purpose: echo front end tuning and drive supply configuration registers
// Assumes: serial pins synchronous to ref_clk and slower than ref_clk / 4
// Notes: frame is read flag, 6-bit address, spare bit, 8 data bits
`timescale 1ns/1ns
module efc_config_regs #(
    parameter int CLK_HZ = efc_pkg::CLK_HZ_DEF
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // serial configuration link
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso_o,
    output logic spi_miso_oe,
    // burst control pins and device state
    input wire logic burst_pin_a,
    input wire logic burst_pin_b,
    input wire logic burst_start,
    input wire logic burst_active,
    input wire logic [1:0] device_state,
    // receive path tuning
    input wire logic [2:0] factory_slope,
    input wire logic [3:0] factory_intercept,
    output logic amp_trim_override,
    output logic [2:0] slope_adjust,
    output logic [3:0] intercept_adjust,
    output logic first_stage_off,
    output logic final_stage_off,
    output logic scale_5v_sel,
    output logic [1:0] preamp_gain,
    // driver io
    output logic [1:0] io_mode,
    output logic [2:0] pulse_fault_deglitch,
    output logic driver_pulse_fault,
    // drive supply
    input wire logic supply_trigger,
    input wire logic supply_at_level,
    output logic auto_charge_off_listen,
    output logic supply_high_impedance,
    output logic charge_current_select,
    output logic [3:0] supply_voltage_code,
    output logic drive_supply_charge_en,
    output logic supply_ready
);
    if (CLK_HZ < efc_pkg::US_PER_S)
    begin : g_bad_clk
        $error("clock below 1 MHz cannot time the deglitch window");
    end

    logic [7:0] log_q, rx_q, io_q, sup_q;
    logic [15:0] sh_q;
    logic [3:0] cnt_q;
    logic sclk_q, cs_n_q, miso_q;
    logic [7:0] stat_q, rd_q;
    logic fault_q, charge_off_q, charge_en_q, ready_q, burst_q;
    logic [2:0] slope_q;
    logic [3:0] icpt_q;

    // serial edge detection; pins are already in the ref_clk domain
    wire in_frame = !spi_cs_n;
    wire frame_start = in_frame && cs_n_q;
    wire bit_rise = in_frame && spi_sclk && !sclk_q;
    wire bit_fall = in_frame && !spi_sclk && sclk_q;
    wire [15:0] sh_nx = {sh_q[14:0], spi_mosi};
    wire hdr_done = bit_rise && cnt_q == efc_pkg::HDR_LAST;
    wire frame_done = bit_rise && cnt_q == efc_pkg::FRAME_LAST;
    wire hdr_rd = sh_nx[efc_pkg::HDR_RW];
    wire [5:0] hdr_addr = sh_nx[efc_pkg::HDR_A_HI:efc_pkg::HDR_A_LO];
    wire wr_en = frame_done && !sh_nx[efc_pkg::BIT_RW];
    wire [5:0] wr_addr = sh_nx[efc_pkg::ADDR_HI:efc_pkg::ADDR_LO];
    wire [7:0] wr_data = sh_nx[7:0];

    // write decode
    wire wr_log = wr_en && wr_addr == efc_pkg::OFF_LOG_TUNE;
    wire wr_rx = wr_en && wr_addr == efc_pkg::OFF_RX_GAIN;
    wire wr_io = wr_en && wr_addr == efc_pkg::OFF_IO_CFG;
    wire wr_sup = wr_en && wr_addr == efc_pkg::OFF_SUPPLY;

    // status byte: same layout in every frame and in the fault register
    logic [7:0] stat_word;
    always_comb
    begin
        stat_word = 8'h00;
        stat_word[efc_pkg::STAT_READY] = ready_q;
        stat_word[efc_pkg::STAT_FAULT] = fault_q;
        stat_word[efc_pkg::STAT_STATE_HI:efc_pkg::STAT_STATE_LO] =
            device_state;
    end

    // read select; unmapped addresses read zero
    wire [7:0] rd_word =
        hdr_addr == efc_pkg::OFF_LOG_TUNE ? log_q :
        hdr_addr == efc_pkg::OFF_RX_GAIN ? rx_q :
        hdr_addr == efc_pkg::OFF_IO_CFG ? io_q :
        hdr_addr == efc_pkg::OFF_SUPPLY ? sup_q :
        hdr_addr == efc_pkg::OFF_FAULT_STAT ? stat_word : 8'h00;

    // reading the fault register clears the flag; a new fault wins
    wire fault_clr = hdr_done && hdr_rd
        && hdr_addr == efc_pkg::OFF_FAULT_STAT;

    // bit that goes out after cnt rising edges: status, then read data
    function automatic logic out_bit(input logic [7:0] st,
        input logic [7:0] rd, input logic [3:0] n);
        logic [15:0] word;
        word = {st, rd};
        return word[4'hF - n];
    endfunction : out_bit

    // charge stop at the end of each burst while auto-off is set and supply_trigger is low
    wire burst_end = burst_q && !burst_active;
    wire auto_off = sup_q[efc_pkg::B_AUTO_OFF] && !supply_trigger;
    wire hiz = sup_q[efc_pkg::B_HIZ];

    // pulse fault checker
    efc_fault_if fif ();
    wire fault_set = fif.fault_set;
    assign fif.io_mode = io_q[efc_pkg::MODE_HI:efc_pkg::MODE_LO];
    assign fif.deglitch = io_q[efc_pkg::DG_HI:efc_pkg::DG_LO];
    assign fif.burst_start = burst_start;
    assign fif.burst_active = burst_active;
    assign fif.pin_a = burst_pin_a;
    assign fif.pin_b = burst_pin_b;

    efc_pulse_fault_det #(
        .CLK_HZ(CLK_HZ)
    ) u_det (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .bus(fif.det)
    );

    // configuration registers; undefined bits are masked on write
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            log_q <= efc_pkg::LOG_TUNE_RST;
            rx_q <= efc_pkg::RX_GAIN_RST;
            io_q <= efc_pkg::IO_CFG_RST;
            sup_q <= efc_pkg::SUPPLY_RST;
        end
        else
        begin
            if (wr_log)
                log_q <= wr_data & efc_pkg::LOG_TUNE_MASK;
            if (wr_rx)
                rx_q <= wr_data & efc_pkg::RX_GAIN_MASK;
            if (wr_io)
                io_q <= wr_data & efc_pkg::IO_CFG_MASK;
            if (wr_sup)
                sup_q <= wr_data & efc_pkg::SUPPLY_MASK;
        end
    end

    // serial shifter and frame counter
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            sh_q <= 16'h0000;
            cnt_q <= 4'h0;
        end
        else
        begin
            sclk_q <= spi_sclk;
            cs_n_q <= spi_cs_n;
            if (frame_start)
                cnt_q <= 4'h0;
            else if (bit_rise)
            begin
                sh_q <= sh_nx;
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // outgoing bits; status is frozen at chip select fall
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stat_q <= 8'h00;
            rd_q <= 8'h00;
            miso_q <= 1'b0;
        end
        else if (frame_start)
        begin
            stat_q <= stat_word;
            rd_q <= 8'h00;
            miso_q <= stat_word[7];
        end
        else
        begin
            if (hdr_done)
                rd_q <= rd_word;
            if (bit_fall)
                miso_q <= out_bit(stat_q, rd_q, cnt_q);
        end
    end

    assign spi_miso_o = miso_q;
    assign spi_miso_oe = in_frame;

    // fault flag, charge control and supply status
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fault_q <= 1'b0;
            burst_q <= 1'b0;
            charge_off_q <= 1'b0;
            charge_en_q <= 1'b0;
            ready_q <= 1'b0;
        end
        else
        begin
            fault_q <= fault_set || (fault_q && !fault_clr);
            burst_q <= burst_active;
            if (burst_end && auto_off)
                charge_off_q <= 1'b1;
            else if (burst_start || !auto_off)
                charge_off_q <= 1'b0;
            charge_en_q <= !hiz && !charge_off_q;
            ready_q <= supply_at_level && !hiz;
        end
    end

    // tuning outputs: override picks register over factory trim
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            slope_q <= 3'h0;
            icpt_q <= 4'h0;
        end
        else if (log_q[efc_pkg::B_OVERRIDE])
        begin
            slope_q <= log_q[efc_pkg::SLOPE_HI:efc_pkg::SLOPE_LO];
            icpt_q <= log_q[efc_pkg::ICPT_HI:efc_pkg::ICPT_LO];
        end
        else
        begin
            slope_q <= factory_slope;
            icpt_q <= factory_intercept;
        end
    end

    assign amp_trim_override = log_q[efc_pkg::B_OVERRIDE];
    assign slope_adjust = slope_q;
    assign intercept_adjust = icpt_q;
    assign first_stage_off = rx_q[efc_pkg::B_FIRST_OFF];
    assign final_stage_off = rx_q[efc_pkg::B_FINAL_OFF];
    assign scale_5v_sel = rx_q[efc_pkg::B_SCALE];
    assign preamp_gain = rx_q[efc_pkg::GAIN_HI:efc_pkg::GAIN_LO];
    assign io_mode = io_q[efc_pkg::MODE_HI:efc_pkg::MODE_LO];
    assign pulse_fault_deglitch = io_q[efc_pkg::DG_HI:efc_pkg::DG_LO];
    assign driver_pulse_fault = fault_q;
    assign auto_charge_off_listen = sup_q[efc_pkg::B_AUTO_OFF];
    assign supply_high_impedance = hiz;
    assign charge_current_select = sup_q[efc_pkg::B_CURRENT];
    assign supply_voltage_code =
        sup_q[efc_pkg::VOLT_HI:efc_pkg::VOLT_LO];
    assign drive_supply_charge_en = charge_en_q;
    assign supply_ready = ready_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    chk_io_write: assert property (
        wr_io |=> io_q == ($past(wr_data) & efc_pkg::IO_CFG_MASK))
        else $error("io config write not stored");
    chk_supply_write: assert property (
        wr_sup |=> supply_voltage_code == $past(wr_data[3:0])
            && charge_current_select == $past(wr_data[4]))
        else $error("drive supply write not stored");
    chk_override_sel: assert property (
        amp_trim_override && !wr_log |=> slope_adjust
            == $past(log_q[efc_pkg::SLOPE_HI:efc_pkg::SLOPE_LO]))
        else $error("override did not select register slope");
    chk_factory_sel: assert property (
        !amp_trim_override |=> intercept_adjust == $past(factory_intercept))
        else $error("factory intercept not used without override");
    chk_fault_sticky: assert property (
        driver_pulse_fault && !fault_clr |=> driver_pulse_fault)
        else $error("pulse fault dropped without a status read");
    chk_fault_set: assert property (
        fault_set |=> driver_pulse_fault)
        else $error("pulse fault event lost");
    chk_charge_off: assert property (
        burst_end && auto_off |=> ##1 !drive_supply_charge_en)
        else $error("charging not stopped after burst");
    chk_hiz_stops: assert property (
        hiz && $past(hiz) |=> !drive_supply_charge_en && !supply_ready)
        else $error("high impedance supply still charging or ready");
    chk_reserved_zero: assert property (
        (rx_q & ~efc_pkg::RX_GAIN_MASK) == 8'h00
            && (io_q & ~efc_pkg::IO_CFG_MASK) == 8'h00)
        else $error("reserved bits hold a value");

    cov_write: cover property (wr_log);
    cov_status_read: cover property (fault_clr && driver_pulse_fault);
    cov_charge_stop: cover property (burst_end && auto_off);
endmodule : efc_config_regs

// file: bench/efc_mcu_model.sv
// Purpose: microcontroller side of the serial configuration link
// Assumes: each sclk level held three or more ref_clk cycles
// Notes: mosi flips after a frame so stale data never looks valid
`timescale 1ns/1ns
module efc_mcu_model
(
    // clock
    input wire logic ref_clk,
    // serial link
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe
);
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // miso taken late in the low phase, long after its update
    task automatic xfer(input logic [15:0] f, output logic [15:0] g);
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge ref_clk);
            spi_cs_n <= 1'b0;
            spi_mosi <= f[i];
            repeat (3) @(posedge ref_clk);
            g[i] = spi_miso_o & spi_miso_oe;
            spi_sclk <= 1'b1;
            repeat (3) @(posedge ref_clk);
            spi_sclk <= 1'b0;
        end
        repeat (3) @(posedge ref_clk);
        spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        @(posedge ref_clk);
    endtask : xfer
endmodule : efc_mcu_model

// file: bench/testbench.sv
// Purpose: self-checking bench for the configuration registers
// Assumes: 10 MHz ref_clk, so one microsecond is ten cycles
// Notes: fault timing is checked a few cycles either side of the limit
`timescale 1ns/1ns
module testbench;
    logic ref_clk, nrst, spi_sclk, spi_cs_n, spi_mosi;
    logic spi_miso_o, spi_miso_oe, burst_pin_a, burst_pin_b;
    logic burst_start, burst_active, supply_trigger, supply_at_level;
    logic [1:0] device_state, preamp_gain, io_mode;
    logic [2:0] factory_slope, slope_adjust, pulse_fault_deglitch;
    logic [3:0] factory_intercept, intercept_adjust, supply_voltage_code;
    logic amp_trim_override, first_stage_off, final_stage_off;
    logic scale_5v_sel, driver_pulse_fault, auto_charge_off_listen;
    logic supply_high_impedance, charge_current_select;
    logic drive_supply_charge_en, supply_ready, exp_flt;
    logic [24:0] got_vec;
    logic [31:0] seed = 32'h15;
    logic [7:0] m[4];
    logic [7:0] mask[4] = '{8'hFF, 8'hC7, 8'h1F, 8'h7F};
    logic [5:0] adr[6] = '{6'h12, 6'h13, 6'h14, 6'h16, 6'h15, 6'h1C};
    int dgu[7] = '{64, 48, 32, 24, 16, 8, 4};
    int err_count = 0, samples_checked = 0, cycles = 0;
    assign got_vec = {amp_trim_override, slope_adjust, intercept_adjust,
        first_stage_off, final_stage_off, scale_5v_sel, preamp_gain,
        pulse_fault_deglitch, io_mode, auto_charge_off_listen,
        supply_high_impedance, charge_current_select, supply_voltage_code};

    efc_config_regs #(.CLK_HZ(10_000_000)) dut_u (.ref_clk, .nrst,
        .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso_o, .spi_miso_oe,
        .burst_pin_a, .burst_pin_b, .burst_start, .burst_active,
        .device_state, .factory_slope, .factory_intercept,
        .amp_trim_override, .slope_adjust, .intercept_adjust,
        .first_stage_off, .final_stage_off, .scale_5v_sel, .preamp_gain,
        .io_mode, .pulse_fault_deglitch, .driver_pulse_fault,
        .supply_trigger, .supply_at_level, .auto_charge_off_listen,
        .supply_high_impedance, .charge_current_select,
        .supply_voltage_code, .drive_supply_charge_en, .supply_ready);
    efc_mcu_model mcu_u (.ref_clk, .spi_sclk, .spi_cs_n, .spi_mosi,
        .spi_miso_o, .spi_miso_oe);

    always #50 ref_clk = ~ref_clk;

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic int idx(input logic [5:0] a);
        for (int i = 0; i < 4; i++)
            if (adr[i] == a)
                return i;
        return -1;
    endfunction : idx

    function automatic logic [24:0] exp_vec();
        logic [6:0] t;
        t = m[0][7] ? m[0][6:0] : {factory_slope, factory_intercept};
        return {m[0][7], t, m[1][7:6], m[1][2:0], m[2][4:0], m[3][6:0]};
    endfunction : exp_vec

    task automatic cmp_rd(input string n, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_rd

    task automatic cmp_out(input string n, input logic [24:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_out

    task automatic frame(input logic rw, input logic [5:0] a,
        input logic [7:0] d8);
        logic [15:0] g;
        logic [31:0] r;
        logic [7:0] st;
        int k;
        k = idx(a);
        r = rnd();
        device_state <= r[1:0];
        st = {2'h0, supply_at_level & ~m[3][5], 1'b0, exp_flt, 3'h0};
        st[1:0] = r[1:0];
        mcu_u.xfer({rw, a, 1'b0, d8}, g);
        cmp_rd("status", st, g[15:8]);
        if (rw && k >= 0)
            cmp_rd("read data", m[k], g[7:0]);
        if (rw && a == 6'h15)
            cmp_rd("unmapped", 8'h00, g[7:0]);
        if (!rw && k >= 0)
            m[k] = d8 & mask[k];
        if (rw && a == 6'h1C)
            exp_flt = 1'b0;
        cmp_out("outputs", exp_vec(),
            got_vec);
    endtask : frame

    task automatic pulse(input logic [1:0] md, input logic [2:0] c,
        input logic [1:0] pins, tog, input int q, input logic e);
        frame(1'b0, 6'h14, {3'h0, c, md});
        {burst_pin_a, burst_pin_b} <= pins;
        @(posedge ref_clk);
        burst_start <= 1'b1;
        burst_active <= 1'b1;
        @(posedge ref_clk);
        burst_start <= 1'b0;
        for (int i = 0; i < q; i++)
        begin
            @(posedge ref_clk);
            if (i % 20 == 19)
                {burst_pin_a, burst_pin_b} <= {burst_pin_a, burst_pin_b} ^ tog;
        end
        cmp_out("fault", {24'h0, e}, {24'h0, driver_pulse_fault});
        burst_active <= 1'b0;
        exp_flt = e;
        frame(1'b1, 6'h1C, 8'h00);
        cmp_out("cleared", 25'h0, {24'h0, driver_pulse_fault});
    endtask : pulse

    task automatic burst(input logic stay, input logic [1:0] e);
        burst_start <= 1'b1;
        burst_active <= 1'b1;
        @(posedge ref_clk);
        burst_start <= 1'b0;
        repeat (4) @(posedge ref_clk);
        burst_active <= stay;
        repeat (3) @(posedge ref_clk);
        cmp_out("charge", {23'h0, e},
            {23'h0, drive_supply_charge_en, supply_ready});
    endtask : burst

    task close_out;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    // hang guard, well above the roughly 17000 cycles the run needs
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            close_out();
        end
    end

    initial
    begin
        {ref_clk, nrst, burst_pin_a, burst_pin_b, burst_start} = 5'h0;
        {burst_active, supply_trigger, supply_at_level} = 3'h1;
        {device_state, factory_slope, factory_intercept} = 9'h0;
        m = '{8'h00, 8'h00, 8'h00, 8'h20};
        exp_flt = 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        cmp_out("reset", exp_vec(), got_vec);
        for (int i = 0; i < 6; i++)
            frame(1'b1, adr[i], 8'h00);
        frame(1'b0, 6'h12, 8'hA5);
        frame(1'b0, 6'h12, 8'h5A);
        for (int i = 0; i < 24; i++)
        begin
            {factory_slope, factory_intercept} <= 7'(rnd());
            frame(1'b0, adr[i % 6], 8'(rnd()));
            frame(1'b1, adr[i % 6], 8'h00);
        end
        for (int c = 0; c < 7; c++)
        begin
            pulse(2'(c % 2), 3'(c), 2'h0, 2'h0, dgu[c] * 10 - 4, 0);
            pulse(2'(c % 2), 3'(c), 2'h0, 2'h0, dgu[c] * 10 + 4, 1);
        end
        pulse(2'h0, 3'h6, 2'h0, 2'h1, 200, 1'b0);
        pulse(2'h1, 3'h6, 2'h0, 2'h2, 100, 1'b1);
        pulse(2'h2, 3'h6, 2'h3, 2'h0, 100, 1'b0);
        pulse(2'h2, 3'h6, 2'h0, 2'h0, 44, 1'b1);
        pulse(2'h3, 3'h6, 2'h0, 2'h0, 100, 1'b0);
        pulse(2'h0, 3'h7, 2'h0, 2'h0, 700, 1'b0);
        frame(1'b0, 6'h16, 8'h46);
        frame(1'b1, 6'h16, 8'h00);
        burst(1'b0, 2'h1);
        burst(1'b1, 2'h3);
        supply_trigger <= 1'b1;
        burst(1'b0, 2'h3);
        frame(1'b0, 6'h16, 8'h20);
        burst(1'b0, 2'h0);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        m = '{8'h00, 8'h00, 8'h00, 8'h20};
        // trim outputs follow the factory inputs one cycle after release
        repeat (2) @(posedge ref_clk);
        cmp_out("reset", exp_vec(), got_vec);
        frame(1'b1, 6'h16, 8'h00);
        close_out();
    end
endmodule : testbench
